//--- rtl/fdc_pkg.sv
package fdc_pkg;

    localparam int ROW_W = 12;
    localparam int COL_W = 10;
    localparam int ADDR_W = ROW_W + COL_W;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int LANES = 2;

    localparam int CLK_MHZ = 25;
    localparam int CLK_PERIOD_NS = 40;

    // strobe phase widths in ns, rounded up to whole cycles
    localparam int ROW_SETUP_NS = 40;
    localparam int ROW_TO_COL_NS = 40;
    localparam int COL_PULSE_NS = 80;
    localparam int COL_PRECHARGE_NS = 40;
    localparam int ROW_PRECHARGE_NS = 80;
    localparam int ROW_PULSE_NS = 80;
    localparam int CAS_SETUP_NS = 40;

    localparam int SELF_ENTRY_US = 100;
    localparam int SELF_EXIT_NS = 120;

    localparam int REFRESH_PERIOD_MS = 64;
    localparam int REFRESH_ROWS = 4096;
    localparam int EXT_REFRESH_US = 125;

    localparam int EXIT_BURST_ROWS = 1024;

    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc

    localparam int ROW_SETUP_CYC = ns_to_cyc(ROW_SETUP_NS);
    localparam int ROW_TO_COL_CYC = ns_to_cyc(ROW_TO_COL_NS);
    localparam int COL_PULSE_CYC = ns_to_cyc(COL_PULSE_NS);
    localparam int COL_PRE_CYC = ns_to_cyc(COL_PRECHARGE_NS);
    localparam int ROW_PRE_CYC = ns_to_cyc(ROW_PRECHARGE_NS);
    localparam int ROW_PULSE_CYC = ns_to_cyc(ROW_PULSE_NS);
    localparam int CAS_SETUP_CYC = ns_to_cyc(CAS_SETUP_NS);
    localparam int SELF_ENTRY_CYC = SELF_ENTRY_US * CLK_MHZ;
    localparam int SELF_EXIT_CYC = ns_to_cyc(SELF_EXIT_NS);
    // longest spacing rounds down
    localparam int STD_INTERVAL_CYC =
        (REFRESH_PERIOD_MS * 1000 * CLK_MHZ) / REFRESH_ROWS;
    localparam int EXT_INTERVAL_CYC = EXT_REFRESH_US * CLK_MHZ;

    localparam int TMR_W = 16;

    localparam logic [1:0] LANE_LOW = 2'h1;
    localparam logic [1:0] LANE_HIGH = 2'h2;
    localparam logic [1:0] LANE_NONE = 2'h0;

    typedef enum logic [1:0] {
        FDC_OP_READ,
        FDC_OP_WRITE,
        FDC_OP_ROW_REFRESH
    } fdc_op_t;

    typedef struct packed {
        fdc_op_t op;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic [LANES-1:0] lanes;
        logic [DATA_W-1:0] wdata;
        logic page_keep;
    } fdc_req_t;

    typedef struct packed {
        logic ras_n;
        logic low_byte_strobe_n;
        logic high_byte_strobe_n;
        logic we_n;
        logic oe_n;
        logic [ROW_W-1:0] addr;
    } fdc_pins_t;

endpackage : fdc_pkg

//--- rtl/fdc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module fdc_timer
    import fdc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [TMR_W-1:0] value_i,
    output logic done_o
);
    logic [TMR_W-1:0] count;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count <= '0;
        end else if (load_i) begin
            count <= value_i;
        end else if (count != '0) begin
            count <= count - TMR_W'(1);
        end
    end

    assign done_o = (count == '0) && !load_i;
endmodule : fdc_timer
`default_nettype wire

//--- rtl/fdc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - 12-bit row then 10-bit column on shared address pins select a word.
// - low strobe alone: DQ0-DQ7; high alone: DQ8-DQ15; both: word.
// - both bytes use one write mode; lanes change mode only after precharge.
// - write select low makes a write; otherwise the cycle reads.
// - output enable low lets the device drive read data.
// - row latched on row strobe fall, column on column strobe fall.
// - page mode: row held low, column strobe toggled per new column.
// - every row refreshed at least once each 64ms.
// - issue 4,096 strobe-reversed refreshes per period, internal row count.
// - row-only refresh strobes a row address with row strobe only.
// - self refresh: strobe-reversed cycle with row held for entry time.
// - self-refresh parts may refresh one row every 125 microseconds.
// - leave self refresh by row strobe high for exit precharge.
// - after exit with burst or row-only refresh, refresh 1,024 rows first.
module fdc_ctrl
    import fdc_pkg::*;
#(
    parameter int SELF_ENTRY_CYCLES = SELF_ENTRY_CYC,
    parameter int STD_INTERVAL_CYCLES = STD_INTERVAL_CYC
)
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic req_valid_i,
    input wire fdc_req_t req_i,
    output logic req_ready_o,
    output logic rdata_valid_o,
    output logic [DATA_W-1:0] rdata_o,
    input wire logic ext_refresh_i,
    input wire logic self_refresh_req_i,
    input wire logic burst_after_exit_i,
    output logic self_refresh_o,
    output logic ras_n_o,
    output logic low_byte_strobe_n_o,
    output logic high_byte_strobe_n_o,
    output logic we_n_o,
    output logic oe_n_o,
    output logic [ROW_W-1:0] addr_o,
    input wire logic [DATA_W-1:0] dq_i,
    output logic [DATA_W-1:0] dq_o,
    output logic [LANES-1:0] dq_oe_o
);

    typedef enum logic [3:0] {
        ST_IDLE, ST_ROW, ST_RCD, ST_COL, ST_PAGE_WAIT, ST_COL_PRE,
        ST_RAS_PRE, ST_CBR_CAS, ST_CBR_RAS, ST_SELF, ST_SELF_EXIT
    } fdc_state_t;

    fdc_state_t state;
    fdc_req_t cur;
    fdc_pins_t pins;
    logic tmr_load;
    logic [TMR_W-1:0] tmr_value;
    logic tmr_done;
    logic [TMR_W-1:0] ref_timer;
    logic [12:0] ref_owed;
    logic [10:0] burst_left;
    logic cbr_selfref;
    logic refresh_due;
    logic [TMR_W-1:0] interval;

    function automatic logic [TMR_W-1:0] cyc(input int n);
        return TMR_W'(n - 1);
    endfunction : cyc

    function automatic logic [1:0] strobe_lanes(input logic [LANES-1:0] l);
        return ~l;
    endfunction : strobe_lanes

    fdc_timer u_timer (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .load_i(tmr_load),
        .value_i(tmr_value),
        .done_o(tmr_done)
    );

    // standard pace kept: it is faster than the relaxed self-refresh pace
    assign interval = TMR_W'(STD_INTERVAL_CYCLES);
    assign refresh_due = (ref_owed != '0) || (burst_left != '0);

    // distributed refresh pacing: one owed cycle each interval
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_timer <= '0;
            ref_owed <= '0;
        end else begin
            if (state == ST_SELF) begin
                ref_timer <= '0;
                ref_owed <= '0;
            end else begin
                if (ref_timer >= interval - TMR_W'(1)) begin
                    ref_timer <= '0;
                end else begin
                    ref_timer <= ref_timer + TMR_W'(1);
                end
                // a new tick and a cycle that pays one off in the same cycle cancel, leaving the count unchanged
                if (ref_timer >= interval - TMR_W'(1)) begin
                    if (!(state == ST_CBR_RAS && tmr_done && ref_owed != '0))
                        ref_owed <= ref_owed + 13'h0001;
                end else if (state == ST_CBR_RAS && tmr_done &&
                             ref_owed != '0 && !cbr_selfref) begin
                    ref_owed <= ref_owed - 13'h0001;
                end
            end
        end
    end

    // burst of rows owed after self-refresh exit
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            burst_left <= '0;
        end else if (state == ST_SELF_EXIT && tmr_done &&
                     burst_after_exit_i) begin
            burst_left <= 11'(EXIT_BURST_ROWS);
        end else if (state == ST_CBR_RAS && tmr_done && ref_owed == '0 &&
                     burst_left != '0 && !cbr_selfref) begin
            burst_left <= burst_left - 11'h001;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
            cur <= '0;
            cbr_selfref <= 1'b0;
            tmr_load <= 1'b0;
            tmr_value <= '0;
            rdata_valid_o <= 1'b0;
            rdata_o <= '0;
            self_refresh_o <= 1'b0;
            req_ready_o <= 1'b0;
        end else begin
            tmr_load <= 1'b0;
            rdata_valid_o <= 1'b0;
            // acknowledge of a take, one cycle late; the requester drops then
            req_ready_o <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (tmr_done) begin
                        if (refresh_due || ext_refresh_i ||
                            self_refresh_req_i) begin
                            cbr_selfref <= self_refresh_req_i &&
                                           !refresh_due;
                            state <= ST_CBR_CAS;
                            tmr_load <= 1'b1;
                            tmr_value <= cyc(CAS_SETUP_CYC);
                        end else if (req_valid_i) begin
                            cur <= req_i;
                            req_ready_o <= 1'b1;
                            state <= ST_ROW;
                            tmr_load <= 1'b1;
                            tmr_value <= cyc(ROW_SETUP_CYC);
                        end
                    end
                end
                ST_ROW: begin
                    if (tmr_done) begin
                        state <= (cur.op == FDC_OP_ROW_REFRESH) ? ST_COL
                                                                : ST_RCD;
                        tmr_load <= 1'b1;
                        tmr_value <= (cur.op == FDC_OP_ROW_REFRESH)
                                     ? cyc(ROW_PULSE_CYC)
                                     : cyc(ROW_TO_COL_CYC);
                    end
                end
                ST_RCD: begin
                    if (tmr_done) begin
                        state <= ST_COL;
                        tmr_load <= 1'b1;
                        tmr_value <= cyc(COL_PULSE_CYC);
                    end
                end
                ST_COL: begin
                    if (tmr_done) begin
                        if (cur.op == FDC_OP_READ) begin
                            rdata_valid_o <= 1'b1;
                            rdata_o <= dq_i;
                        end
                        state <= ST_PAGE_WAIT;
                    end
                end
                ST_PAGE_WAIT: begin
                    // byte strobes are high here, row strobe stays low: column precharge starts
                    if (cur.page_keep && cur.op != FDC_OP_ROW_REFRESH &&
                        req_valid_i && req_i.op != FDC_OP_ROW_REFRESH &&
                        req_i.row == cur.row) begin
                        cur <= req_i;
                        req_ready_o <= 1'b1;
                        state <= ST_COL_PRE;
                        tmr_load <= 1'b1;
                        tmr_value <= cyc(COL_PRE_CYC);
                    end else begin
                        state <= ST_RAS_PRE;
                        tmr_load <= 1'b1;
                        tmr_value <= cyc(ROW_PRE_CYC);
                    end
                end
                ST_COL_PRE: begin
                    if (tmr_done) begin
                        state <= ST_COL;
                        tmr_load <= 1'b1;
                        tmr_value <= cyc(COL_PULSE_CYC);
                    end
                end
                ST_RAS_PRE: begin
                    if (tmr_done) begin
                        state <= ST_IDLE;
                    end
                end
                ST_CBR_CAS: begin
                    if (tmr_done) begin
                        state <= ST_CBR_RAS;
                        tmr_load <= 1'b1;
                        tmr_value <= cbr_selfref
                                     ? cyc(SELF_ENTRY_CYCLES)
                                     : cyc(ROW_PULSE_CYC);
                    end
                end
                ST_CBR_RAS: begin
                    if (tmr_done) begin
                        if (cbr_selfref) begin
                            state <= ST_SELF;
                            self_refresh_o <= 1'b1;
                        end else begin
                            state <= ST_RAS_PRE;
                            tmr_load <= 1'b1;
                            tmr_value <= cyc(ROW_PRE_CYC);
                        end
                    end
                end
                ST_SELF: begin
                    if (!self_refresh_req_i) begin
                        state <= ST_SELF_EXIT;
                        tmr_load <= 1'b1;
                        tmr_value <= cyc(SELF_EXIT_CYC);
                    end
                end
                ST_SELF_EXIT: begin
                    if (tmr_done) begin
                        self_refresh_o <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // pin drive derived from the state, registered onto the outputs
    always_comb begin
        pins = '{ras_n: 1'b1, low_byte_strobe_n: 1'b1,
                 high_byte_strobe_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                 addr: cur.row};
        unique case (state)
            ST_ROW, ST_RCD, ST_PAGE_WAIT, ST_COL_PRE: begin
                pins.ras_n = (state == ST_ROW);
                pins.we_n = (cur.op != FDC_OP_WRITE);
                // row stays on the pins past the row strobe fall
                if (state != ST_ROW && state != ST_RCD) begin
                    pins.addr = ROW_W'(cur.col);
                end
            end
            ST_COL: begin
                pins.ras_n = 1'b0;
                pins.addr = (cur.op == FDC_OP_ROW_REFRESH)
                            ? cur.row : ROW_W'(cur.col);
                if (cur.op != FDC_OP_ROW_REFRESH) begin
                    {pins.high_byte_strobe_n, pins.low_byte_strobe_n} =
                        strobe_lanes(cur.lanes);
                end
                pins.we_n = (cur.op != FDC_OP_WRITE);
                pins.oe_n = (cur.op != FDC_OP_READ);
            end
            ST_CBR_CAS, ST_CBR_RAS, ST_SELF: begin
                pins.low_byte_strobe_n = 1'b0;
                pins.high_byte_strobe_n = 1'b0;
                pins.ras_n = (state == ST_CBR_CAS);
            end
            default: begin
                pins.ras_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ras_n_o <= 1'b1;
            low_byte_strobe_n_o <= 1'b1;
            high_byte_strobe_n_o <= 1'b1;
            we_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            addr_o <= '0;
            dq_o <= '0;
            dq_oe_o <= '0;
        end else begin
            ras_n_o <= pins.ras_n;
            low_byte_strobe_n_o <= pins.low_byte_strobe_n;
            high_byte_strobe_n_o <= pins.high_byte_strobe_n;
            we_n_o <= pins.we_n;
            oe_n_o <= pins.oe_n;
            addr_o <= pins.addr;
            dq_o <= cur.wdata;
            // per-lane drive only on the strobed byte lanes
            dq_oe_o <= (state == ST_COL && cur.op == FDC_OP_WRITE)
                       ? cur.lanes : LANE_NONE;
        end
    end

endmodule : fdc_ctrl
`default_nettype wire

//--- testbench/fdc_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fdc_ctrl_checker
    import fdc_pkg::*;
#(
    parameter int SELF_ENTRY_CYCLES = SELF_ENTRY_CYC
)
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic rdata_valid_o,
    input wire logic self_refresh_o,
    input wire logic ras_n_o,
    input wire logic low_byte_strobe_n_o,
    input wire logic high_byte_strobe_n_o,
    input wire logic we_n_o,
    input wire logic oe_n_o,
    input wire logic [ROW_W-1:0] addr_o,
    input wire logic [LANES-1:0] dq_oe_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic cas_on;
    logic [TMR_W-1:0] low_cnt;
    assign cas_on = !low_byte_strobe_n_o || !high_byte_strobe_n_o;
    // saturates so a long self refresh cannot wrap back under the limit
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_cnt <= '0;
        end else if (ras_n_o) begin
            low_cnt <= '0;
        end else if (low_cnt != '1) begin
            low_cnt <= low_cnt + TMR_W'(1);
        end
    end
    property p_cbr_order;
        $fell(ras_n_o) && cas_on |-> $past(cas_on);
    endproperty
    a_cbr_order: assert property (p_cbr_order)
        else $error("strobe late");
    property p_col_hold;
        !ras_n_o && cas_on && $past(cas_on) |-> $stable(addr_o);
    endproperty
    a_col_hold: assert property (p_col_hold)
        else $error("addr moved");
    property p_col_pulse;
        $rose(cas_on) && !ras_n_o |-> cas_on [*2];
    endproperty
    a_col_pulse: assert property (p_col_pulse)
        else $error("short strobe");
    property p_no_clash;
        !oe_n_o |-> dq_oe_o == '0;
    endproperty
    a_no_clash: assert property (p_no_clash)
        else $error("bus clash");
    property p_write_quiet;
        !we_n_o |-> oe_n_o;
    endproperty
    a_write_quiet: assert property (p_write_quiet)
        else $error("oe in write");
    property p_ras_pre;
        $rose(ras_n_o) |-> ras_n_o [*2];
    endproperty
    a_ras_pre: assert property (p_ras_pre)
        else $error("short precharge");
    property p_rd_oe;
        rdata_valid_o |-> !$past(oe_n_o) ##1 !rdata_valid_o;
    endproperty
    a_rd_oe: assert property (p_rd_oe)
        else $error("bad read pulse");
    property p_self_entry;
        $rose(ras_n_o) && $past(self_refresh_o)
            |-> low_cnt >= SELF_ENTRY_CYCLES;
    endproperty
    a_self_entry: assert property (p_self_entry)
        else $error("entry too short");
    property p_self_exit;
        $rose(ras_n_o) && $past(self_refresh_o) |-> ras_n_o [*3];
    endproperty
    a_self_exit: assert property (p_self_exit)
        else $error("exit too short");
endmodule : fdc_ctrl_checker
bind fdc_ctrl fdc_ctrl_checker #(
    .SELF_ENTRY_CYCLES(SELF_ENTRY_CYCLES)
) fdc_ctrl_checker_inst (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .rdata_valid_o(rdata_valid_o),
    .self_refresh_o(self_refresh_o),
    .ras_n_o(ras_n_o),
    .low_byte_strobe_n_o(low_byte_strobe_n_o),
    .high_byte_strobe_n_o(high_byte_strobe_n_o),
    .we_n_o(we_n_o),
    .oe_n_o(oe_n_o),
    .addr_o(addr_o),
    .dq_oe_o(dq_oe_o)
);
`default_nettype wire

//--- testbench/fdc_dram_model.sv
`timescale 1ns/1ps
`default_nettype none
module fdc_dram_model
    import fdc_pkg::*;
#(
    parameter int ENTRY_CYCLES = 4
)
(
    input wire logic core_clk_i,
    input wire fdc_pins_t pins_i,
    input wire logic [DATA_W-1:0] dq_i,
    output logic [DATA_W-1:0] dq_o,
    output logic [LANES-1:0] dq_oe_o,
    output var int cbr_cnt_o,
    output var int ras_cnt_o,
    output logic self_o,
    output logic [ROW_W-1:0] row_o
);
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] rd = '0;
    logic [COL_W-1:0] col = '0;
    logic [1:0] sn;
    logic ras_q = 1'b1;
    logic cas_q = 1'b0;
    logic strobe_reversed_refresh = 1'b0;
    logic cas;
    int low_n = 0;
    int k;
    assign sn = {pins_i.high_byte_strobe_n, pins_i.low_byte_strobe_n};
    assign cas = sn != 2'h3;
    initial begin
        cbr_cnt_o = 0;
        ras_cnt_o = 0;
        self_o = 1'b0;
        row_o = '0;
    end
    // pins are looked at mid-cycle, where the controller's outputs are settled
    always @(negedge core_clk_i) begin
        if (ras_q && !pins_i.ras_n) begin
            strobe_reversed_refresh = cas_q;
            if (cas_q) begin
                cbr_cnt_o++;
            end else begin
                row_o = pins_i.addr;
                ras_cnt_o++;
            end
        end
        if (pins_i.ras_n) begin
            low_n = 0;
            self_o = 1'b0;
            strobe_reversed_refresh = 1'b0;
        end else if (strobe_reversed_refresh) begin
            low_n++;
            if (low_n >= ENTRY_CYCLES) begin
                self_o = 1'b1;
            end
        end
        if (!pins_i.ras_n && !strobe_reversed_refresh && cas && !cas_q) begin
            col = pins_i.addr[COL_W-1:0];
        end
        k = int'({row_o, col});
        for (int l = 0; l < LANES; l++) begin
            if (!pins_i.ras_n && !strobe_reversed_refresh && !sn[l] && !pins_i.we_n) begin
                mem[k][l*BYTE_W +: BYTE_W] = dq_i[l*BYTE_W +: BYTE_W];
            end
        end
        rd = mem.exists(k) ? mem[k] : ~rd;
        ras_q = pins_i.ras_n;
        cas_q = cas;
    end
    // an idle lane shows the inverse, never a held copy of the last data
    always @* begin
        for (int l = 0; l < LANES; l++) begin
            dq_oe_o[l] = !pins_i.ras_n && !strobe_reversed_refresh && !sn[l] && !pins_i.oe_n
                && pins_i.we_n;
        end
        dq_o = rd ^ ~{{BYTE_W{dq_oe_o[1]}}, {BYTE_W{dq_oe_o[0]}}};
    end
endmodule : fdc_dram_model
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import fdc_pkg::*;
    logic core_clk_i, rst_n_i, req_valid_i, ext_refresh_i;
    logic self_refresh_req_i, burst_after_exit_i;
    logic req_ready_o, rdata_valid_o, self_refresh_o, self_m;
    logic [DATA_W-1:0] rdata_o, dq_o, m_dq, bus, rd;
    logic [DATA_W-1:0] own;
    logic [LANES-1:0] dq_oe_o, m_oe;
    logic [ROW_W-1:0] row_m;
    fdc_req_t req_i;
    fdc_pins_t pins;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    int cbr_cnt, ras_cnt, c0;
    assign own = {{BYTE_W{dq_oe_o[1]}}, {BYTE_W{dq_oe_o[0]}}};
    assign bus = (dq_o & own) | (m_dq & ~own);
    fdc_ctrl #(.SELF_ENTRY_CYCLES(4), .STD_INTERVAL_CYCLES(60)) fdc_ctrl_inst (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
        .rdata_valid_o(rdata_valid_o), .rdata_o(rdata_o),
        .ext_refresh_i(ext_refresh_i), .self_refresh_req_i(self_refresh_req_i),
        .burst_after_exit_i(burst_after_exit_i),
        .self_refresh_o(self_refresh_o), .ras_n_o(pins.ras_n),
        .low_byte_strobe_n_o(pins.low_byte_strobe_n),
        .high_byte_strobe_n_o(pins.high_byte_strobe_n),
        .we_n_o(pins.we_n), .oe_n_o(pins.oe_n), .addr_o(pins.addr),
        .dq_i(bus), .dq_o(dq_o), .dq_oe_o(dq_oe_o));
    fdc_dram_model #(.ENTRY_CYCLES(4)) fdc_dram_model_inst (
        .core_clk_i(core_clk_i), .pins_i(pins), .dq_i(bus), .dq_o(m_dq),
        .dq_oe_o(m_oe), .cbr_cnt_o(cbr_cnt), .ras_cnt_o(ras_cnt),
        .self_o(self_m), .row_o(row_m));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    // holds the request until the take acknowledge is seen
    task automatic access(input fdc_op_t op, input logic [11:0] row,
        input logic [9:0] col, input logic [1:0] ln, input logic [15:0] wd,
        input logic keep);
        int n;
        n = 0;
        @(posedge core_clk_i);
        req_i <= '{op, row, col, ln, wd, keep};
        req_valid_i <= 1'b1;
        do @(negedge core_clk_i);
        while (req_ready_o !== 1'b1 && n++ < 20000);
        if (n > 20000) err_count++;
        @(posedge core_clk_i);
        req_valid_i <= 1'b0;
        n = 0;
        if (op == FDC_OP_READ) begin
            do @(negedge core_clk_i);
            while (rdata_valid_o !== 1'b1 && n++ < 20);
            if (n > 20) err_count++;
            rd = rdata_o;
        end
    endtask : access
    task automatic t_word();
        access(FDC_OP_WRITE, 12'hFFF, 10'h3FF, 2'h3, 16'hA5C3, 1'b0);
        access(FDC_OP_WRITE, 12'h000, 10'h000, 2'h3, 16'h5A3C, 1'b0);
        access(FDC_OP_READ, 12'hFFF, 10'h3FF, 2'h3, 16'h0000, 1'b0);
        chk(rd, 16'hA5C3);
        access(FDC_OP_READ, 12'h000, 10'h000, 2'h3, 16'h0000, 1'b0);
        chk(rd, 16'h5A3C);
        $display("done word");
    endtask : t_word
    task automatic t_bytes();
        access(FDC_OP_WRITE, 12'h123, 10'h045, 2'h3, 16'h0000, 1'b0);
        access(FDC_OP_WRITE, 12'h123, 10'h045, LANE_LOW, 16'hFFAA, 1'b0);
        access(FDC_OP_WRITE, 12'h123, 10'h045, LANE_HIGH, 16'h55FF, 1'b0);
        access(FDC_OP_READ, 12'h123, 10'h045, 2'h3, 16'h0000, 1'b0);
        chk(rd, 16'h55AA);
        access(FDC_OP_READ, 12'h123, 10'h045, LANE_HIGH, 16'h0000, 1'b0);
        chk(rd[15:8], 8'h55);
        $display("done bytes");
    endtask : t_bytes
    task automatic t_page();
        c0 = cbr_cnt;
        // start just after a refresh so none falls inside the open page
        repeat (200) if (cbr_cnt == c0) @(posedge core_clk_i);
        c0 = ras_cnt;
        access(FDC_OP_WRITE, 12'h2A0, 10'h010, 2'h3, 16'hC0DE, 1'b1);
        access(FDC_OP_WRITE, 12'h2A0, 10'h011, 2'h3, 16'hBEEF, 1'b1);
        access(FDC_OP_READ, 12'h2A0, 10'h010, 2'h3, 16'h0000, 1'b0);
        chk(rd, 16'hC0DE);
        chk(ras_cnt - c0, 1);
        access(FDC_OP_READ, 12'h2A0, 10'h011, 2'h3, 16'h0000, 1'b0);
        chk(rd, 16'hBEEF);
        chk(ras_cnt - c0, 2);
        $display("done page");
    endtask : t_page
    task automatic t_rowref();
        c0 = ras_cnt;
        access(FDC_OP_ROW_REFRESH, 12'h5A5, 10'h000, 2'h0, 16'h0000, 1'b0);
        repeat (4) @(posedge core_clk_i);
        chk(row_m, 12'h5A5);
        chk(ras_cnt - c0, 1);
        $display("done row refresh");
    endtask : t_rowref
    task automatic t_cbr();
        c0 = cbr_cnt;
        ext_refresh_i <= 1'b1;
        repeat (100) if (cbr_cnt == c0) @(posedge core_clk_i);
        ext_refresh_i <= 1'b0;
        repeat (600) @(posedge core_clk_i);
        chk(cbr_cnt - c0 >= 10 && cbr_cnt - c0 <= 12, 1);
        $display("done refresh");
    endtask : t_cbr
    task automatic t_self();
        burst_after_exit_i <= 1'b1;
        self_refresh_req_i <= 1'b1;
        repeat (500) if (self_refresh_o !== 1'b1) @(negedge core_clk_i);
        repeat (10) @(posedge core_clk_i);
        chk(self_m, 1'b1);
        self_refresh_req_i <= 1'b0;
        c0 = cbr_cnt;
        repeat (50) if (self_refresh_o !== 1'b0) @(negedge core_clk_i);
        repeat (2) @(posedge core_clk_i);
        chk(self_m, 1'b0);
        access(FDC_OP_WRITE, 12'h0F0, 10'h00F, 2'h3, 16'h1357, 1'b0);
        chk(cbr_cnt - c0 >= EXIT_BURST_ROWS, 1);
        access(FDC_OP_READ, 12'h0F0, 10'h00F, 2'h3, 16'h0000, 1'b0);
        chk(rd, 16'h1357);
        burst_after_exit_i <= 1'b0;
        $display("done self refresh");
    endtask : t_self
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        rst_n_i = 1'b0;
        req_valid_i = 1'b0;
        req_i = '0;
        ext_refresh_i = 1'b0;
        self_refresh_req_i = 1'b0;
        burst_after_exit_i = 1'b0;
        repeat (4) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        t_word();
        t_bytes();
        t_page();
        t_rowref();
        t_cbr();
        t_self();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
